// *** core/xcm_pkg.sv ***
package xcm_pkg;
  // Width of the in-channel offset on the narrow and the wide variant.
  localparam int XCM_OFS_W_NARROW = 10;
  localparam int XCM_OFS_W_WIDE = 11;
  // Default channel count and configuration data width.
  localparam int XCM_NUM_CH_DEF = 4;
  localparam int XCM_DATA_W = 32;
  // Lowest channel-select bit sits directly above the offset field.
  localparam int XCM_CH_SEL_LSB_NARROW = XCM_OFS_W_NARROW;
  localparam int XCM_CH_SEL_LSB_WIDE = XCM_OFS_W_WIDE;
  // Reset value of every read data register.
  localparam logic [XCM_DATA_W-1:0] XCM_RDATA_RST = 32'h0000_0000;
  // Debug frame: bit 0 is the write flag, then the address, then the data.
  localparam int XCM_DBG_WR_POS = 0;
  localparam int XCM_DBG_ADDR_POS = 1;
  // Cycles from a granted debug read to its captured data.
  localparam int XCM_DBG_RD_LAT = 1;

  // Debug master sequencing, one-hot.
  typedef enum logic [2:0] {
    XCM_DBG_SHIFT = 3'b001,
    XCM_DBG_REQ = 3'b010,
    XCM_DBG_WAIT = 3'b100
  } xcm_dbg_state_t;
endpackage

// *** core/xcm_ch_space.sv ***
`timescale 1ns/100ps
module xcm_ch_space
  import xcm_pkg::*;
#(
  parameter int OFFSET_W = XCM_OFS_W_NARROW,
  parameter int DATA_W = XCM_DATA_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Access port
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [OFFSET_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] rdata_o
);
  // The array has no reset; only the read register is defined after reset.
  logic [DATA_W-1:0] mem_q [0:(1<<OFFSET_W)-1];
  logic [DATA_W-1:0] rdata_q;

  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= XCM_RDATA_RST[DATA_W-1:0];
    end else if (rd_i) begin
      rdata_q <= mem_q[addr_i];
    end
  end

  assign rdata_o = rdata_q;
endmodule

// *** core/xcm_dbg_master.sv ***
`timescale 1ns/100ps
module xcm_dbg_master
  import xcm_pkg::*;
#(
  parameter int ADDR_W = XCM_OFS_W_NARROW + 2,
  parameter int DATA_W = XCM_DATA_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Serial scan side, sampled on mclk
  input wire logic scan_sel_i,
  input wire logic scan_tck_i,
  input wire logic scan_tdi_i,
  output logic scan_tdo_o,
  // Access request toward the router
  output logic req_o,
  output logic req_wr_o,
  output logic [ADDR_W-1:0] req_addr_o,
  output logic [DATA_W-1:0] req_wdata_o,
  input wire logic grant_i,
  input wire logic rvalid_i,
  input wire logic [DATA_W-1:0] rdata_i,
  output logic busy_o
);
  localparam int FRAME_W = 1 + ADDR_W + DATA_W;
  localparam int DATA_POS = XCM_DBG_ADDR_POS + ADDR_W;

  xcm_dbg_state_t state_q;
  logic [FRAME_W-1:0] shift_q;
  logic tck_q;
  logic sel_q;
  logic tck_rise;
  logic sel_fall;

  assign tck_rise = scan_tck_i & ~tck_q;
  assign sel_fall = sel_q & ~scan_sel_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tck_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      tck_q <= scan_tck_i;
      sel_q <= scan_sel_i;
    end
  end

  // Shifting is held off while an access is in flight so the frame stays intact.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_q <= '0;
    end else if (state_q == XCM_DBG_SHIFT && scan_sel_i && tck_rise) begin
      shift_q <= {scan_tdi_i, shift_q[FRAME_W-1:1]};
    end else if (state_q == XCM_DBG_WAIT && rvalid_i) begin
      shift_q[FRAME_W-1:DATA_POS] <= rdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= XCM_DBG_SHIFT;
    end else begin
      case (state_q)
        XCM_DBG_SHIFT: begin
          if (sel_fall) begin
            state_q <= XCM_DBG_REQ;
          end
        end
        XCM_DBG_REQ: begin
          if (grant_i) begin
            state_q <= req_wr_o ? XCM_DBG_SHIFT : XCM_DBG_WAIT;
          end
        end
        XCM_DBG_WAIT: begin
          if (rvalid_i) begin
            state_q <= XCM_DBG_SHIFT;
          end
        end
        default: begin
          state_q <= XCM_DBG_SHIFT;
        end
      endcase
    end
  end

  assign req_o = (state_q == XCM_DBG_REQ);
  assign req_wr_o = shift_q[XCM_DBG_WR_POS];
  assign req_addr_o = shift_q[XCM_DBG_ADDR_POS +: ADDR_W];
  assign req_wdata_o = shift_q[DATA_POS +: DATA_W];
  assign scan_tdo_o = shift_q[0];
  assign busy_o = (state_q != XCM_DBG_SHIFT);
endmodule

// *** core/xcm_cfg_router.sv ***
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module xcm_cfg_router
  import xcm_pkg::*;
#(
  parameter int NUM_CH = XCM_NUM_CH_DEF,
  parameter int OFFSET_W = XCM_OFS_W_NARROW,
  parameter int DATA_W = XCM_DATA_W,
  parameter bit DYN_CFG_EN = 1'b1,
  parameter bit SHARED_EN = 1'b1,
  parameter bit SEPARATE_EN = 1'b0,
  parameter bit EMBEDDED_DEBUG_MASTER_OPTION = 1'b1,
  // Derived widths; not meant to be overridden.
  parameter int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 0,
  parameter int SH_AW = OFFSET_W + CH_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Shared configuration port
  input wire logic [SH_AW-1:0] sh_addr_i,
  input wire logic [DATA_W-1:0] sh_wdata_i,
  input wire logic sh_wr_i,
  input wire logic sh_rd_i,
  output logic [DATA_W-1:0] sh_rdata_o,
  // Unshared ports, one slice per channel
  input wire logic [NUM_CH*OFFSET_W-1:0] sp_addr_i,
  input wire logic [NUM_CH*DATA_W-1:0] sp_wdata_i,
  input wire logic [NUM_CH-1:0] sp_wr_i,
  input wire logic [NUM_CH-1:0] sp_rd_i,
  output logic [NUM_CH*DATA_W-1:0] sp_rdata_o,
  // Per-channel resets for separate ports
  input wire logic [NUM_CH-1:0] sp_rst_b_i,
  // Serial scan link of the embedded debug master
  input wire logic scan_sel_i,
  input wire logic scan_tck_i,
  input wire logic scan_tdi_i,
  output logic scan_tdo_o,
  // Status
  output logic shared_mode_o,
  output logic separate_mode_o,
  output logic debug_active_o,
  output logic debug_busy_o
);
  localparam int CH_WX = (CH_W == 0) ? 1 : CH_W;
  // Separate ports are only honoured while sharing is off.
  localparam bit SEP_EFF = SEPARATE_EN && !SHARED_EN;
  localparam bit SH_EFF = SHARED_EN && DYN_CFG_EN;
  localparam bit DBG_EFF = EMBEDDED_DEBUG_MASTER_OPTION && DYN_CFG_EN &&
    ((NUM_CH == 1) || SHARED_EN);

  // Shared-port decode
  logic [CH_WX-1:0] usr_ch;
  logic usr_ch_ok;
  logic usr_wr;
  logic usr_rd;
  // Debug path
  logic dbg_req;
  logic dbg_req_wr;
  logic [SH_AW-1:0] dbg_req_addr;
  logic [DATA_W-1:0] dbg_req_wdata;
  logic dbg_grant;
  logic [CH_WX-1:0] dbg_ch;
  logic dbg_ch_ok;
  logic dbg_busy;
  logic dbg_tdo;
  // Read-return tracking
  logic usr_rd_q;
  logic usr_oor_q;
  logic [CH_WX-1:0] usr_ch_q;
  logic dbg_rd_q;
  logic dbg_oor_q;
  logic [CH_WX-1:0] dbg_ch_q;
  logic [NUM_CH-1:0] sp_rd_q;
  logic [DATA_W-1:0] dbg_rdata;
  // Channel-space side
  logic [NUM_CH-1:0] ch_wr;
  logic [NUM_CH-1:0] ch_rd;
  logic [NUM_CH*OFFSET_W-1:0] ch_addr;
  logic [NUM_CH*DATA_W-1:0] ch_wdata;
  logic [NUM_CH*DATA_W-1:0] ch_rdata;

  // Without dynamic configuration the port is closed and strobes are dropped.
  assign usr_wr = SH_EFF && sh_wr_i;
  assign usr_rd = SH_EFF && sh_rd_i;

  generate
    if (CH_W == 0) begin : g_single
      assign usr_ch = '0;
      assign dbg_ch = '0;
    end else begin : g_multi
      assign usr_ch = sh_addr_i[SH_AW-1 -: CH_WX];
      assign dbg_ch = dbg_req_addr[SH_AW-1 -: CH_WX];
    end
  endgenerate

  // Indices past the last channel are legal to issue but reach nothing.
  assign usr_ch_ok = (32'(usr_ch) < NUM_CH);
  assign dbg_ch_ok = (32'(dbg_ch) < NUM_CH);

  // The user master never waits, so debug only takes idle cycles.
  // In split mode the slice strobes are user traffic too, so they hold debug off.
  assign dbg_grant = DBG_EFF && dbg_req && !usr_wr && !usr_rd &&
    (SH_EFF || !(|(sp_wr_i | sp_rd_i)));

  generate
    if (DBG_EFF) begin : g_dbg
      xcm_dbg_master #(
        .ADDR_W(SH_AW),
        .DATA_W(DATA_W)
      ) u_dbg (
        .clk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .scan_sel_i(scan_sel_i),
        .scan_tck_i(scan_tck_i),
        .scan_tdi_i(scan_tdi_i),
        .scan_tdo_o(dbg_tdo),
        .req_o(dbg_req),
        .req_wr_o(dbg_req_wr),
        .req_addr_o(dbg_req_addr),
        .req_wdata_o(dbg_req_wdata),
        .grant_i(dbg_grant),
        .rvalid_i(dbg_rd_q),
        .rdata_i(dbg_rdata),
        .busy_o(dbg_busy)
      );
    end else begin : g_no_dbg
      assign dbg_tdo = 1'b0;
      assign dbg_req = 1'b0;
      assign dbg_req_wr = 1'b0;
      assign dbg_req_addr = '0;
      assign dbg_req_wdata = '0;
      assign dbg_busy = 1'b0;
    end
  endgenerate

  // Per-channel steering into the configuration spaces.
  generate
    for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
      logic usr_hit;
      logic dbg_hit;
      logic ch_rst_b;

      assign usr_hit = usr_ch_ok && (32'(usr_ch) == k);
      assign dbg_hit = dbg_grant && dbg_ch_ok && (32'(dbg_ch) == k);

      if (SH_EFF) begin : g_sh
        assign ch_wr[k] = (usr_wr && usr_hit) || (dbg_hit && dbg_req_wr);
        assign ch_rd[k] = (usr_rd && usr_hit) || (dbg_hit && !dbg_req_wr);
        assign ch_addr[k*OFFSET_W +: OFFSET_W] = (usr_wr || usr_rd) ?
          sh_addr_i[OFFSET_W-1:0] : dbg_req_addr[OFFSET_W-1:0];
        assign ch_wdata[k*DATA_W +: DATA_W] = usr_wr ? sh_wdata_i : dbg_req_wdata;
      end else if (DYN_CFG_EN) begin : g_sp
        // Each channel answers to its own slice of the wide bus and to granted debug accesses.
        assign ch_wr[k] = sp_wr_i[k] || (dbg_hit && dbg_req_wr);
        assign ch_rd[k] = sp_rd_i[k] || (dbg_hit && !dbg_req_wr);
        assign ch_addr[k*OFFSET_W +: OFFSET_W] = (sp_wr_i[k] || sp_rd_i[k]) ?
          sp_addr_i[k*OFFSET_W +: OFFSET_W] : dbg_req_addr[OFFSET_W-1:0];
        assign ch_wdata[k*DATA_W +: DATA_W] = sp_wr_i[k] ?
          sp_wdata_i[k*DATA_W +: DATA_W] : dbg_req_wdata;
      end else begin : g_off
        assign ch_wr[k] = 1'b0;
        assign ch_rd[k] = 1'b0;
        assign ch_addr[k*OFFSET_W +: OFFSET_W] = '0;
        assign ch_wdata[k*DATA_W +: DATA_W] = '0;
      end

      // A separate port carries its own reset; otherwise the common one rules.
      if (SEP_EFF) begin : g_own_rst
        assign ch_rst_b = rst_b_i & sp_rst_b_i[k];
      end else begin : g_com_rst
        assign ch_rst_b = rst_b_i;
      end

      xcm_ch_space #(
        .OFFSET_W(OFFSET_W),
        .DATA_W(DATA_W)
      ) u_space (
        .clk_i(mclk_i),
        .rst_b_i(ch_rst_b),
        .wr_i(ch_wr[k]),
        .rd_i(ch_rd[k]),
        .addr_i(ch_addr[k*OFFSET_W +: OFFSET_W]),
        .wdata_i(ch_wdata[k*DATA_W +: DATA_W]),
        .rdata_o(ch_rdata[k*DATA_W +: DATA_W])
      );

      always_ff @(posedge mclk_i or negedge ch_rst_b) begin
        if (!ch_rst_b) begin
          sp_rd_q[k] <= 1'b0;
        end else begin
          sp_rd_q[k] <= !SH_EFF && DYN_CFG_EN && sp_rd_i[k];
        end
      end

      // Read data stand only in the cycle after the read strobe.
      assign sp_rdata_o[k*DATA_W +: DATA_W] = sp_rd_q[k] ?
        ch_rdata[k*DATA_W +: DATA_W] : '0;
    end
  endgenerate

  // Shared-port read return tracking.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      usr_rd_q <= 1'b0;
      usr_oor_q <= 1'b0;
      usr_ch_q <= '0;
    end else begin
      usr_rd_q <= usr_rd;
      usr_oor_q <= usr_rd && !usr_ch_ok;
      usr_ch_q <= usr_ch;
    end
  end

  // Debug read return tracking.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dbg_rd_q <= 1'b0;
      dbg_oor_q <= 1'b0;
      dbg_ch_q <= '0;
    end else begin
      dbg_rd_q <= dbg_grant && !dbg_req_wr;
      dbg_oor_q <= dbg_grant && !dbg_ch_ok;
      dbg_ch_q <= dbg_ch;
    end
  end

  // Out-of-range reads still return, with zero data.
  always_comb begin
    sh_rdata_o = '0;
    dbg_rdata = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (usr_rd_q && !usr_oor_q && (32'(usr_ch_q) == i)) begin
        sh_rdata_o = ch_rdata[i*DATA_W +: DATA_W];
      end
      if (dbg_rd_q && !dbg_oor_q && (32'(dbg_ch_q) == i)) begin
        dbg_rdata = ch_rdata[i*DATA_W +: DATA_W];
      end
    end
  end

  assign scan_tdo_o = dbg_tdo;
  assign shared_mode_o = SH_EFF;
  assign separate_mode_o = SEP_EFF && DYN_CFG_EN;
  assign debug_active_o = DBG_EFF;
  assign debug_busy_o = dbg_busy;
endmodule

// *** bench/xcm_cfg_router_props.sv ***
`timescale 1ns/100ps
module xcm_chk
  import xcm_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int OFFSET_W = 10,
  parameter int DATA_W = 32,
  parameter bit DYN_CFG_EN = 1'b1,
  parameter bit SHARED_EN = 1'b1,
  parameter int SH_AW = 12
) (
  // Watched ports
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [SH_AW-1:0] sh_addr_i,
  input wire logic sh_rd_i,
  input wire logic [DATA_W-1:0] sh_rdata_o,
  input wire logic [NUM_CH-1:0] sp_rd_i,
  input wire logic [NUM_CH*DATA_W-1:0] sp_rdata_o,
  input wire logic scan_sel_i,
  input wire logic shared_mode_o,
  input wire logic separate_mode_o,
  input wire logic debug_active_o,
  input wire logic debug_busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_frame_end;
    debug_active_o && $fell(scan_sel_i) && !debug_busy_o;
  endsequence
  sequence s_finish;
    ##[1:40] !debug_busy_o;
  endsequence
  property p_rd_idle; !$past(sh_rd_i) |-> sh_rdata_o == '0; endproperty
  property p_oor; sh_rd_i && (sh_addr_i >> OFFSET_W) >= NUM_CH |=> sh_rdata_o == '0; endproperty
  property p_quiet; !shared_mode_o |-> sh_rdata_o == '0; endproperty
  property p_one_port; shared_mode_o |-> sp_rdata_o == '0; endproperty
  property p_sp_idle; !$past(sp_rd_i[0]) |-> sp_rdata_o[DATA_W-1:0] == '0; endproperty
  property p_excl; !(shared_mode_o && separate_mode_o); endproperty
  property p_mode; shared_mode_o == (SHARED_EN && DYN_CFG_EN); endproperty
  property p_dbg_ok; debug_active_o |-> DYN_CFG_EN && (NUM_CH == 1 || shared_mode_o); endproperty
  property p_no_dbg; !debug_active_o |-> !debug_busy_o; endproperty
  property p_dbg_start; s_frame_end |=> debug_busy_o; endproperty
  property p_dbg_done; $rose(debug_busy_o) |-> s_finish; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  a_oor: assert property (p_oor) else $error("unmapped channel read not zero");
  a_quiet: assert property (p_quiet) else $error("shared port answered while off");
  a_one_port: assert property (p_one_port) else $error("split port answered");
  a_sp_idle: assert property (p_sp_idle) else $error("slice data outside answer");
  a_excl: assert property (p_excl) else $error("both port modes on");
  a_mode: assert property (p_mode) else $error("shared mode flag wrong");
  a_dbg_ok: assert property (p_dbg_ok) else $error("debug master not allowed");
  a_no_dbg: assert property (p_no_dbg) else $error("busy without debug master");
  a_dbg_start: assert property (p_dbg_start) else $error("frame end did not start");
  a_dbg_done: assert property (p_dbg_done) else $error("debug access hung");
endmodule

bind xcm_cfg_router xcm_chk #(.NUM_CH(NUM_CH), .OFFSET_W(OFFSET_W), .DATA_W(DATA_W),
  .DYN_CFG_EN(DYN_CFG_EN), .SHARED_EN(SHARED_EN), .SH_AW(SH_AW)) chk_u (.mclk_i, .rst_b_i,
  .sh_addr_i, .sh_rd_i, .sh_rdata_o, .sp_rd_i, .sp_rdata_o, .scan_sel_i, .shared_mode_o,
  .separate_mode_o, .debug_active_o, .debug_busy_o);

// *** bench/xcm_cfg_master.sv ***
`timescale 1ns/100ps
module xcm_cfg_master
  import xcm_pkg::*;
#(
  parameter int FW = 1 + 12 + XCM_DATA_W
) (
  // Clock
  input wire logic mclk_i,
  // Shared port
  output logic [11:0] addr_o,
  output logic [XCM_DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [XCM_DATA_W-1:0] rdata_i,
  // Scan link
  output logic sel_o,
  output logic tck_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  initial begin
    {addr_o, wdata_o, wr_o, rd_o, sel_o, tck_o, tdi_o} = '0;
  end
  // Released lines carry the inverse, so a late sample never matches by luck.
  task automatic acc(input bit w, input logic [1:0] ch, input logic [9:0] ofs,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    addr_o <= {ch, ofs};
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge mclk_i);
    {wr_o, rd_o} <= 2'h0;
    addr_o <= ~{ch, ofs};
    wdata_o <= ~d;
    #1 q = rdata_i;
  endtask
  task automatic frame(input logic [FW-1:0] f, output logic [FW-1:0] o);
    @(posedge mclk_i);
    sel_o <= 1'b1;
    for (int i = 0; i < FW; i++) begin
      @(posedge mclk_i);
      tck_o <= 1'b0;
      tdi_o <= f[i];
      @(posedge mclk_i);
      #1 o[i] = tdo_i;
      @(posedge mclk_i);
      tck_o <= 1'b1;
      @(posedge mclk_i);
    end
    @(posedge mclk_i);
    tck_o <= 1'b0;
    tdi_o <= ~f[FW-1];
    @(posedge mclk_i);
    sel_o <= 1'b0;
  endtask
endmodule

// *** bench/tb_xcm_cfg_router.sv ***
`timescale 1ns/100ps
module tb_xcm_cfg_router
  import xcm_pkg::*;
;
  localparam int NC = 3;
  localparam int FW = 1 + 12 + XCM_DATA_W;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [NC*10-1:0] sp_addr = '0;
  logic [NC*32-1:0] sp_wdata = '0;
  logic [NC-1:0] sp_wr = '0, sp_rd = '0, sp_rst_b = '1;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, rdata3;
  logic tdo2, sm3, pm3, da3;
  logic [NC*32-1:0] sp_rdata;
  logic wr, rd, sel, tck, tdi, tdo, sm, pm, da, db, sm2, pm2, da2;
  int error_cnt = 0, comparisons = 0, cyc = 0;

  xcm_cfg_master m_u (.mclk_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata), .sel_o(sel), .tck_o(tck), .tdi_o(tdi), .tdo_i(tdo));
  xcm_cfg_router #(.NUM_CH(NC)) dut_u (.mclk_i, .rst_b_i, .sh_addr_i(addr),
    .sh_wdata_i(wdata), .sh_wr_i(wr), .sh_rd_i(rd), .sh_rdata_o(rdata), .sp_addr_i(sp_addr),
    .sp_wdata_i(sp_wdata), .sp_wr_i(sp_wr), .sp_rd_i(sp_rd), .sp_rdata_o(),
    .sp_rst_b_i(sp_rst_b), .scan_sel_i(sel), .scan_tck_i(tck), .scan_tdi_i(tdi),
    .scan_tdo_o(tdo), .shared_mode_o(sm), .separate_mode_o(pm), .debug_active_o(da),
    .debug_busy_o(db));
  xcm_cfg_router #(.NUM_CH(NC), .SHARED_EN(1'b0), .SEPARATE_EN(1'b1))
    dut_sep_u (.mclk_i, .rst_b_i, .sh_addr_i(addr),
    .sh_wdata_i(wdata), .sh_wr_i(wr), .sh_rd_i(rd), .sh_rdata_o(), .sp_addr_i(sp_addr),
    .sp_wdata_i(sp_wdata), .sp_wr_i(sp_wr), .sp_rd_i(sp_rd), .sp_rdata_o(sp_rdata),
    .sp_rst_b_i(sp_rst_b), .scan_sel_i(sel), .scan_tck_i(tck), .scan_tdi_i(tdi),
    .scan_tdo_o(tdo2), .shared_mode_o(sm2), .separate_mode_o(pm2), .debug_active_o(da2),
    .debug_busy_o());
  xcm_cfg_router #(.NUM_CH(NC), .DYN_CFG_EN(1'b0)) dut_off_u (.mclk_i, .rst_b_i,
    .sh_addr_i(addr), .sh_wdata_i(wdata), .sh_wr_i(wr), .sh_rd_i(rd), .sh_rdata_o(rdata3),
    .sp_addr_i(sp_addr), .sp_wdata_i(sp_wdata), .sp_wr_i(sp_wr), .sp_rd_i(sp_rd),
    .sp_rdata_o(), .sp_rst_b_i(sp_rst_b), .scan_sel_i(sel), .scan_tck_i(tck),
    .scan_tdi_i(tdi), .scan_tdo_o(), .shared_mode_o(sm3), .separate_mode_o(pm3),
    .debug_active_o(da3), .debug_busy_o());

  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic sp_acc(input int k, input bit w, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    sp_addr[k*10 +: 10] <= 10'h155;
    sp_wdata[k*32 +: 32] <= d;
    sp_wr[k] <= w;
    sp_rd[k] <= !w;
    @(posedge mclk_i);
    sp_wr[k] <= 1'b0;
    sp_rd[k] <= 1'b0;
    sp_addr[k*10 +: 10] <= 10'h2aa;
    sp_wdata[k*32 +: 32] <= ~d;
    #1 q = sp_rdata[k*32 +: 32];
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge mclk_i);
    while (db === 1'b1 && n < 60) begin
      @(posedge mclk_i);
      n++;
    end
    chk(db, 32'h0, "debug idle");
  endtask
  task automatic t_modes();
    chk(sm, 32'h1, "shared flag");
    chk(pm, 32'h0, "separate flag off");
    chk(da, 32'h1, "debug built");
    chk(pm2, 32'h1, "separate flag on");
    chk(sm2, 32'h0, "shared flag off");
    chk(da2, 32'h0, "debug absent");
    chk(tdo2, 32'h0, "absent debug output quiet");
    chk(sm3, 32'h0, "closed port not shared");
    chk(pm3, 32'h0, "closed port not separate");
    chk(da3, 32'h0, "closed port has no debug");
    $display("test modes done");
  endtask
  task automatic t_shared();
    logic [31:0] q;
    for (int c = 0; c < NC; c++) begin
      m_u.acc(1'b1, c[1:0], 10'h3ff, 32'hc0de_0000 | c, q);
      m_u.acc(1'b1, c[1:0], 10'h000, 32'h0000_5a00 | c, q);
    end
    for (int c = 0; c < NC; c++) begin
      m_u.acc(1'b0, c[1:0], 10'h3ff, 32'h0, q);
      chk(q, 32'hc0de_0000 | c, "top offset");
      chk(rdata3, 32'h0, "closed port read");
      m_u.acc(1'b0, c[1:0], 10'h000, 32'h0, q);
      chk(q, 32'h0000_5a00 | c, "base offset");
    end
    m_u.acc(1'b1, 2'h3, 10'h3ff, 32'hdead_beef, q);
    m_u.acc(1'b0, 2'h3, 10'h3ff, 32'h0, q);
    chk(q, 32'h0, "unmapped channel read");
    m_u.acc(1'b0, 2'h0, 10'h3ff, 32'h0, q);
    chk(q, 32'hc0de_0000, "unmapped write dropped");
    $display("test shared done");
  endtask
  task automatic t_split();
    logic [31:0] q;
    for (int k = 0; k < NC; k++) sp_acc(k, 1'b1, 32'h600d_0000 | k, q);
    for (int k = 0; k < NC; k++) begin
      sp_acc(k, 1'b0, 32'h0, q);
      chk(q, 32'h600d_0000 | k, "split slice");
    end
    @(posedge mclk_i);
    sp_rst_b[1] <= 1'b0;
    sp_acc(1, 1'b0, 32'h0, q);
    chk(q, 32'h0, "slice held in reset");
    @(posedge mclk_i);
    sp_rst_b[1] <= 1'b1;
    $display("test split done");
  endtask
  task automatic t_debug();
    logic [FW-1:0] o;
    logic [31:0] q;
    m_u.frame({32'h1234_abcd, 2'h1, 10'h020, 1'b1}, o);
    wait_idle();
    m_u.acc(1'b0, 2'h1, 10'h020, 32'h0, q);
    chk(q, 32'h1234_abcd, "debug write");
    m_u.frame({32'h0, 2'h2, 10'h3ff, 1'b0}, o);
    wait_idle();
    m_u.frame({32'h0, 2'h3, 10'h3ff, 1'b0}, o);
    chk(o[FW-1:13], 32'hc0de_0002, "debug read");
    wait_idle();
    m_u.frame({32'h0, 2'h0, 10'h000, 1'b0}, o);
    chk(o[FW-1:13], 32'h0, "debug unmapped read");
    wait_idle();
    $display("test debug done");
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_modes();
    t_shared();
    t_split();
    t_debug();
    close_out();
  end
endmodule
